// >>> design/sli_pkg.sv
// Constants and types shared by the front-panel lamp indicator.
// Assumes one 40 MHz system clock drives every lamp process.
package sli_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned CAN_CHANNELS = 4;
  localparam int unsigned ADDON_COUNT = 4;
  localparam int unsigned TICK_CNT_W = 20;
  localparam int unsigned PHASE_W = 6;
  localparam int unsigned FLASH_W = 3;
  // Phase counter bit that sets each rate; a higher bit is a slower blink
  localparam int unsigned FAST_BIT = 2;
  localparam int unsigned SLOW_BIT = 5;
  localparam int unsigned PASSIVE_BIT = 4;
  localparam int unsigned BUSOFF_BIT = 5;
  localparam int unsigned ADDON_BIT = 4;
  // Short error-frame flash length in ticks
  localparam logic [FLASH_W-1:0] FLASH_TICKS = 3'h5;
  localparam logic [FLASH_W-1:0] FLASH_RST = 3'h0;
  localparam logic [TICK_CNT_W-1:0] TICK_RST = 20'h00000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 6'h00;

  typedef struct packed {
    logic err_passive;
    logic bus_off;
    logic err_frame;
  } sli_can_status_t;

  typedef struct packed {
    logic red;
    logic yellow;
  } sli_can_lamp_t;

  typedef struct packed {
    logic fast;
    logic slow;
    logic passive;
    logic busoff;
    logic addon;
  } sli_phase_t;

  typedef enum logic [1:0] {
    NET_IDLE = 2'h0,
    NET_LEASE = 2'h1,
    NET_READY = 2'h3,
    NET_CONN = 2'h2
  } sli_net_mode_t;
endpackage

// >>> design/sli_tick_gen.sv
// Divided flash tick and the blink phases derived from it.
// Assumes TICK_CYCLES_P is at least 2 and fits the tick counter.
`timescale 1ns/1ps
`default_nettype none
module sli_tick_gen
  import sli_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES // Cycles per tick
) (
  input wire logic clock_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic enable_i, // Clock enable
  output logic tick_o, // One-cycle tick pulse
  output sli_phase_t phase_o // Blink phase levels
);
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic [PHASE_W-1:0] phase_cnt_reg;
  logic tick_reg;
  logic wrap;

  assign wrap = (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES_P - 1));

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt_reg <= TICK_RST;
      tick_reg <= 1'b0;
    end
    else if (enable_i)
    begin
      tick_cnt_reg <= wrap ? TICK_RST : tick_cnt_reg + TICK_CNT_W'(1);
      tick_reg <= wrap;
    end
  end

  // One binary counter yields all rates, so their edges never drift apart
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      phase_cnt_reg <= PHASE_RST;
    else if (enable_i && tick_reg)
      phase_cnt_reg <= phase_cnt_reg + PHASE_W'(1);
  end

  assign tick_o = tick_reg;
  assign phase_o.fast = phase_cnt_reg[FAST_BIT];
  assign phase_o.slow = phase_cnt_reg[SLOW_BIT];
  assign phase_o.passive = phase_cnt_reg[PASSIVE_BIT];
  assign phase_o.busoff = phase_cnt_reg[BUSOFF_BIT];
  assign phase_o.addon = phase_cnt_reg[ADDON_BIT];
endmodule
`default_nettype wire

// >>> design/sli_can_lamp.sv
// Red and yellow lamp pair of one CAN channel.
// Assumes error-state levels and a one-cycle error-frame strobe.
`timescale 1ns/1ps
`default_nettype none
module sli_can_lamp
  import sli_pkg::*;
(
  input wire logic clock_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic enable_i, // Clock enable
  input wire logic tick_i, // Flash tick pulse
  input wire sli_phase_t phase_i, // Blink phases
  input wire sli_can_status_t status_i, // Channel error status
  output sli_can_lamp_t lamp_o // Lamp drive, active high
);
  logic [FLASH_W-1:0] flash_cnt_reg;
  logic [FLASH_W-1:0] flash_cnt_next;
  sli_can_lamp_t lamp_reg;
  logic quiet;

  assign quiet = !status_i.bus_off && !status_i.err_passive;

  always_comb
  begin
    flash_cnt_next = flash_cnt_reg;
    // A pending flash is dropped once an error state takes the lamp
    if (!quiet)
      flash_cnt_next = FLASH_RST;
    else if (status_i.err_frame)
      flash_cnt_next = FLASH_TICKS;
    else if (tick_i && (flash_cnt_reg != FLASH_RST))
      flash_cnt_next = flash_cnt_reg - FLASH_W'(1);
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      flash_cnt_reg <= FLASH_RST;
    else if (enable_i)
      flash_cnt_reg <= flash_cnt_next;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      lamp_reg <= '0;
    else if (enable_i)
    begin
      if (status_i.bus_off)
        lamp_reg.red <= phase_i.busoff;
      else if (status_i.err_passive)
        lamp_reg.red <= phase_i.passive;
      else
        lamp_reg.red <= (flash_cnt_next != FLASH_RST);
      lamp_reg.yellow <= !quiet && phase_i.passive;
    end
  end

  assign lamp_o = lamp_reg;
endmodule
`default_nettype wire

// >>> design/sli_indicator_top.sv
// Front-panel lamp driver: power, network and CAN channel lamps of the
// base unit, and the power lamp of each add-on module.
// Assumes status inputs are synchronous levels, except each channel's
// error-frame strobe, which is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - The base unit drives ten lamps: power, network, and a yellow and red lamp per CAN channel.
// - The power lamp is steadily lit while the unit is powered and running normally.
// - The network lamp flashes fast while an address lease is awaited.
// - The network lamp flashes slowly while the unit is ready for a remote connection.
// - The network lamp is steadily lit while a host holds a remote connection.
// - In error passive a channel's red and yellow lamps both blink.
// - In bus off the red lamp blinks slower than in error passive and the yellow keeps blinking.
// - An error frame gives one short red flash and leaves the yellow lamp alone.
// - An add-on power lamp is steadily lit while the module is powered and linked.
// - An add-on power lamp flashes while the module is powered but not linked.
module sli_indicator_top
  import sli_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES // Cycles per flash tick
) (
  input wire logic clock_i, // System clock, 40 MHz
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic enable_i, // Clock enable, freezes all state when low
  input wire logic power_good_i, // Supply is within range
  input wire logic unit_ok_i, // Unit reports normal operation
  input wire logic lease_wait_i, // Waiting for an address lease
  input wire logic remote_ready_i, // Ready for a remote connection
  input wire logic remote_conn_i, // Host holds a remote connection
  input wire sli_can_status_t [CAN_CHANNELS-1:0] can_status_i, // CAN error status
  input wire logic [ADDON_COUNT-1:0] addon_power_i, // Add-on module powered
  input wire logic [ADDON_COUNT-1:0] addon_link_i, // Add-on link exchanging data
  output logic pwr_lamp_o, // Green power lamp
  output logic net_lamp_o, // Yellow network lamp
  output wire sli_can_lamp_t [CAN_CHANNELS-1:0] can_lamp_o, // CAN lamp pairs
  output wire logic [ADDON_COUNT-1:0] addon_lamp_o // Add-on power lamps
);
  logic tick;
  sli_phase_t phase;
  sli_net_mode_t net_mode_reg;
  logic pwr_lamp_reg;
  logic net_lamp_reg;

  // Connection outranks readiness, readiness outranks the lease wait
  function automatic sli_net_mode_t net_mode_of(
    input logic conn,
    input logic ready,
    input logic lease
  );
    sli_net_mode_t mode;
    if (conn)
      mode = NET_CONN;
    else if (ready)
      mode = NET_READY;
    else if (lease)
      mode = NET_LEASE;
    else
      mode = NET_IDLE;
    return mode;
  endfunction

  function automatic logic net_lamp_of(
    input sli_net_mode_t mode,
    input sli_phase_t ph
  );
    logic lit;
    lit = 1'b0;
    case (mode)
      NET_LEASE: lit = ph.fast;
      NET_READY: lit = ph.slow;
      NET_CONN: lit = 1'b1;
      default: lit = 1'b0;
    endcase
    return lit;
  endfunction

  sli_tick_gen #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_tick (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(enable_i),
    .tick_o(tick),
    .phase_o(phase)
  );

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      pwr_lamp_reg <= 1'b0;
    else if (enable_i)
      pwr_lamp_reg <= power_good_i && unit_ok_i;
  end

  // Inputs are decoded into a mode first, which costs one cycle of latency
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      net_mode_reg <= NET_IDLE;
    else if (enable_i)
      net_mode_reg <= net_mode_of(remote_conn_i, remote_ready_i, lease_wait_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      net_lamp_reg <= 1'b0;
    else if (enable_i)
      net_lamp_reg <= net_lamp_of(net_mode_reg, phase);
  end

  assign pwr_lamp_o = pwr_lamp_reg;
  assign net_lamp_o = net_lamp_reg;

  generate
    for (genvar c = 0; c < CAN_CHANNELS; c++)
    begin : g_can
      sli_can_lamp u_can (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .enable_i(enable_i),
        .tick_i(tick),
        .phase_i(phase),
        .status_i(can_status_i[c]),
        .lamp_o(can_lamp_o[c])
      );
    end
  endgenerate

  generate
    for (genvar m = 0; m < ADDON_COUNT; m++)
    begin : g_addon
      logic lamp_reg;
      // An unpowered module shows a dark lamp
      always_ff @(posedge clock_i)
      begin
        if (!reset_n_i)
          lamp_reg <= 1'b0;
        else if (enable_i)
        begin
          if (!addon_power_i[m])
            lamp_reg <= 1'b0;
          else if (addon_link_i[m])
            lamp_reg <= 1'b1;
          else
            lamp_reg <= phase.addon;
        end
      end
      assign addon_lamp_o[m] = lamp_reg;
    end
  endgenerate

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence lease_held_s;
    (enable_i && lease_wait_i && !remote_ready_i && !remote_conn_i) [*2];
  endsequence

  sequence ready_held_s;
    (enable_i && remote_ready_i && !remote_conn_i) [*2];
  endsequence

  sequence conn_held_s;
    (enable_i && remote_conn_i) [*2];
  endsequence

  pwr_lamp_steady_a: assert property (
    enable_i |=> pwr_lamp_o == $past(power_good_i && unit_ok_i))
    else $error("power lamp does not follow power and unit state");

  net_lease_fast_a: assert property (
    lease_held_s |=> net_lamp_o == $past(phase.fast))
    else $error("network lamp not at fast rate during lease wait");

  net_ready_slow_a: assert property (
    ready_held_s |=> net_lamp_o == $past(phase.slow))
    else $error("network lamp not at slow rate when ready");

  net_conn_steady_a: assert property (
    conn_held_s |=> net_lamp_o)
    else $error("network lamp dark while connected");

  net_idle_dark_a: assert property (
    (enable_i && !lease_wait_i && !remote_ready_i && !remote_conn_i) [*2]
    |=> !net_lamp_o)
    else $error("network lamp lit with no network state");

  phase_on_tick_a: assert property (
    $changed(phase.fast) |-> $past(tick))
    else $error("fast phase moved without a tick");

  busoff_slower_a: assert property (
    $changed(phase.busoff) |-> $fell(phase.passive))
    else $error("bus-off phase not half the passive rate");

  slow_slower_a: assert property (
    $changed(phase.slow) |-> $fell(phase.fast))
    else $error("slow phase changed off a fast phase edge");

  // A tick caught by a low clock enable is held on purpose, so only enabled ticks count
  tick_single_a: assert property (
    (tick && enable_i) |=> !tick)
    else $error("tick lasted more than one cycle");

  // Runs through reset on purpose: every lamp must go dark one edge into it
  reset_dark_a: assert property (disable iff (1'b0)
    !reset_n_i |=> !pwr_lamp_o && !net_lamp_o && (can_lamp_o == '0)
      && (addon_lamp_o == '0))
    else $error("a lamp stayed lit through reset");

  pwr_lamp_dark_a: assert property (
    (enable_i && !unit_ok_i) |=> !pwr_lamp_o)
    else $error("power lamp lit while the unit reports a fault");

  net_conn_wins_a: assert property (
    (enable_i && remote_conn_i && remote_ready_i && lease_wait_i) [*2] |=> net_lamp_o)
    else $error("connection did not outrank other network states");

  net_ready_wins_a: assert property (
    (enable_i && remote_ready_i && lease_wait_i && !remote_conn_i) [*2]
    |=> net_lamp_o == $past(phase.slow))
    else $error("readiness did not outrank the lease wait");

  generate
    for (genvar c = 0; c < CAN_CHANNELS; c++)
    begin : g_can_chk
      sequence frame_quiet_s;
        enable_i && can_status_i[c].err_frame
          && !can_status_i[c].err_passive && !can_status_i[c].bus_off;
      endsequence

      can_passive_blink_a: assert property (
        (enable_i && can_status_i[c].err_passive && !can_status_i[c].bus_off)
        |=> can_lamp_o[c].red == $past(phase.passive)
          && can_lamp_o[c].yellow == $past(phase.passive))
        else $error("error passive lamps not blinking together");

      can_busoff_blink_a: assert property (
        (enable_i && can_status_i[c].bus_off)
        |=> can_lamp_o[c].red == $past(phase.busoff)
          && can_lamp_o[c].yellow == $past(phase.passive))
        else $error("bus off lamps not at their rates");

      can_frame_flash_a: assert property (
        frame_quiet_s |=> can_lamp_o[c].red && !can_lamp_o[c].yellow)
        else $error("error frame gave no short red flash");

      can_frame_hold_a: assert property (
        frame_quiet_s ##1 (enable_i && !can_status_i[c].err_passive
          && !can_status_i[c].bus_off && !tick) |=> can_lamp_o[c].red)
        else $error("short flash ended before its first tick");

      can_yellow_quiet_a: assert property (
        (enable_i && !can_status_i[c].err_passive && !can_status_i[c].bus_off)
        |=> !can_lamp_o[c].yellow)
        else $error("yellow lamp lit with no error state");

      can_busoff_wins_a: assert property (
        (enable_i && can_status_i[c].bus_off && can_status_i[c].err_passive
          && can_status_i[c].err_frame)
        |=> can_lamp_o[c].red == $past(phase.busoff))
        else $error("bus off did not outrank other error states");

      can_flash_cancel_a: assert property (
        (enable_i && (can_status_i[c].err_passive || can_status_i[c].bus_off))
        ##1 (enable_i && !can_status_i[c].err_passive && !can_status_i[c].bus_off
          && !can_status_i[c].err_frame) |=> !can_lamp_o[c].red)
        else $error("error state left a pending short flash behind");
    end
  endgenerate

  generate
    for (genvar m = 0; m < ADDON_COUNT; m++)
    begin : g_addon_chk
      addon_linked_a: assert property (
        (enable_i && addon_power_i[m] && addon_link_i[m]) |=> addon_lamp_o[m])
        else $error("linked add-on lamp not steady");

      addon_unlinked_a: assert property (
        (enable_i && addon_power_i[m] && !addon_link_i[m])
        |=> addon_lamp_o[m] == $past(phase.addon))
        else $error("unlinked add-on lamp not flashing");

      addon_unpowered_a: assert property (
        (enable_i && !addon_power_i[m]) |=> !addon_lamp_o[m])
        else $error("unpowered add-on lamp lit");
    end
  endgenerate

  freeze_hold_a: assert property (
    !enable_i |=> $stable(phase) && $stable(net_lamp_o) && $stable(pwr_lamp_o))
    else $error("state moved while clock enable was low");

  freeze_lamps_a: assert property (
    !enable_i |=> $stable(can_lamp_o) && $stable(addon_lamp_o) && $stable(tick))
    else $error("lamp state moved while clock enable was low");
endmodule
`default_nettype wire

// >>> verification/sli_lamp_view.sv
// Operator model: watches one front-panel lamp and measures its pattern.
// Assumes clear_i is driven off the clock edge by the bench.
`timescale 1ns/1ps
`default_nettype none
module sli_lamp_view
(
  input wire logic clock_i, // System clock
  input wire logic clear_i, // Restart the measurement
  input wire logic lamp_i, // Lamp drive, high = lit
  output logic [15:0] rises_o, // Turn-on count since clear
  output logic [15:0] high_o, // Lit cycles since clear
  output logic [15:0] cycles_o, // Cycles since clear
  output logic [15:0] period_o // Cycles between the last two turn-ons
);
  logic prev_reg;
  logic [15:0] since_reg;

  // The first turn-on only starts the period count, so a partial
  // period seen after clear is never reported
  always_ff @(posedge clock_i)
  begin
    prev_reg <= lamp_i;
    if (clear_i)
    begin
      rises_o <= 16'h0000;
      high_o <= 16'h0000;
      cycles_o <= 16'h0000;
      period_o <= 16'h0000;
      since_reg <= 16'h0000;
    end
    else
    begin
      cycles_o <= cycles_o + 16'h0001;
      high_o <= high_o + {15'h0000, lamp_i};
      since_reg <= since_reg + 16'h0001;
      if (lamp_i && !prev_reg)
      begin
        rises_o <= rises_o + 16'h0001;
        if (rises_o != 16'h0000)
          period_o <= since_reg;
        since_reg <= 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/sli_indicator_top_tb.sv
// Self-checking bench for the front-panel lamp driver.
// Assumes a short flash tick; lamps are judged by operator models.
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin error_cnt++; \
  $display("BAD t=%0t got %0h exp %0h", $time, act, exp); end end
module sli_indicator_top_tb
  import sli_pkg::*;
;
  // Lamp code: 0 dark, 1 steady, else blink period in cycles
  typedef struct {
    logic [4:0] net;
    int ch;
    sli_can_status_t st;
    logic [3:0] apwr;
    logic [3:0] alink;
    logic [15:0] e_pwr;
    logic [15:0] e_net;
    logic [15:0] e_red;
    logic [15:0] e_yel;
  } sli_row_t;
  logic clock_i = 1'b0;
  logic reset_n = 1'b0;
  logic enable = 1'b1;
  logic pg = 1'b0, ok = 1'b0, lease = 1'b0, ready = 1'b0, conn = 1'b0;
  sli_can_status_t [CAN_CHANNELS-1:0] can_st = '0;
  logic [ADDON_COUNT-1:0] apwr = 4'h0, alink = 4'h0;
  logic pwr, net, clear = 1'b1;
  sli_can_lamp_t [CAN_CHANNELS-1:0] can_lamp;
  logic [ADDON_COUNT-1:0] alamp;
  logic [13:0] lamps;
  logic [15:0] rises [14], high [14], cyc [14], period [14];
  sli_row_t rows [5], r;
  int error_cnt = 0, total_checks = 0, cycle_cnt = 0;

  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end

  sli_indicator_top #(.TICK_CYCLES_P(4)) i_dut (.clock_i(clock_i), .reset_n_i(reset_n),
    .enable_i(enable), .power_good_i(pg), .unit_ok_i(ok), .lease_wait_i(lease),
    .remote_ready_i(ready), .remote_conn_i(conn), .can_status_i(can_st),
    .addon_power_i(apwr), .addon_link_i(alink), .pwr_lamp_o(pwr), .net_lamp_o(net),
    .can_lamp_o(can_lamp), .addon_lamp_o(alamp));

  assign lamps[1:0] = {net, pwr};
  assign lamps[13:10] = alamp;
  for (genvar c = 0; c < 4; c++)
  begin : g_can
    assign lamps[2+c] = can_lamp[c].red;
    assign lamps[6+c] = can_lamp[c].yellow;
  end
  for (genvar k = 0; k < 14; k++)
  begin : g_view
    sli_lamp_view i_view (.clock_i(clock_i), .clear_i(clear), .lamp_i(lamps[k]),
      .rises_o(rises[k]), .high_o(high[k]), .cycles_o(cyc[k]), .period_o(period[k]));
  end

  function automatic logic [15:0] cls(input int k);
    if (high[k] == 16'h0000) return 16'h0000;
    if (high[k] == cyc[k]) return 16'h0001;
    if (rises[k] < 16'h0002) return 16'hffff;
    return period[k];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic measure(input int n);
    clear = 1'b1;
    step(1);
    clear = 1'b0;
    step(n);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is about 3400 cycles
  always @(posedge clock_i)
  begin
    cycle_cnt++;
    if (cycle_cnt == 8000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    rows[0] = '{5'h1c, 0, 3'h4, 4'hf, 4'hf, 16'h0001, 16'h0020, 16'h0080, 16'h0080};
    rows[1] = '{5'h12, 1, 3'h2, 4'h5, 4'h1, 16'h0000, 16'h0100, 16'h0100, 16'h0080};
    rows[2] = '{5'h1f, 2, 3'h7, 4'hf, 4'h0, 16'h0001, 16'h0001, 16'h0100, 16'h0080};
    rows[3] = '{5'h08, 3, 3'h0, 4'h0, 4'hf, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    rows[4] = '{5'h1e, 3, 3'h4, 4'ha, 4'hf, 16'h0001, 16'h0100, 16'h0080, 16'h0080};
    step(10);
    `CHK({lamps}, 14'h0000)
    reset_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      r = rows[i];
      {pg, ok, lease, ready, conn} = r.net;
      for (int c = 0; c < CAN_CHANNELS; c++)
        can_st[c] = (c == r.ch) ? r.st : '0;
      apwr = r.apwr;
      alink = r.alink;
      step(20);
      measure(600);
      `CHK(cls(0), r.e_pwr)
      `CHK(cls(1), r.e_net)
      for (int c = 0; c < 4; c++)
      begin
        `CHK(cls(2 + c), (c == r.ch) ? r.e_red : 16'h0000)
        `CHK(cls(6 + c), (c == r.ch) ? r.e_yel : 16'h0000)
      end
      for (int m = 0; m < 4; m++)
      begin
        `CHK(cls(10 + m), !apwr[m] ? 16'h0000 : alink[m] ? 16'h0001 : 16'h0080)
      end
    end
    // Short flash: one-cycle error frame on an otherwise healthy channel
    {pg, ok, lease, ready, conn} = 5'h18;
    can_st = '0;
    step(5);
    measure(2);
    can_st[0].err_frame = 1'b1;
    step(1);
    can_st[0].err_frame = 1'b0;
    step(40);
    `CHK(rises[2], 16'h0001)
    `CHK((high[2] >= 16'h0010) && (high[2] <= 16'h0015), 1'b1)
    `CHK(high[6], 16'h0000)
    // A frozen design must not advance the blink
    lease = 1'b1;
    step(5);
    enable = 1'b0;
    measure(100);
    `CHK(rises[1], 16'h0000)
    enable = 1'b1;
    measure(100);
    `CHK(period[1], 16'h0020)
    // Reset in mid-run darkens every lamp
    reset_n = 1'b0;
    step(3);
    `CHK({lamps}, 14'h0000)
    reset_n = 1'b1;
    step(5);
    wrap_up();
  end
endmodule
`default_nettype wire
